/* biu_pkg.sv */
// package for the external bus interface arbiter
// assumes a single 100 MHz processor clock domain
package biu_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 26;  // word address, lines 27 down to 2
  localparam int SPACE_W = 4;
  localparam int DATA_W = 32;
  localparam int LANE_W = 4;
  localparam int WAIT_W = 4;
  localparam int FIFO_DEPTH = 4;
  // core request word: atomic, read, size, byte offset, space, address,
  // store data
  localparam int REQ_W = 1 + 1 + 2 + 2 + SPACE_W + ADDR_W + DATA_W;

  // ---------------------------------------------------------------
  // transfer sizes and lane encoding
  // ---------------------------------------------------------------
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [3:0] LANES_NONE_N = 4'hf;
  localparam logic [WAIT_W-1:0] WAIT_RST = 4'h0;

  // ---------------------------------------------------------------
  // bus state machine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_XFER = 3'b001,
    ST_ATOM_WR = 3'b010,
    ST_GRANT = 3'b011,
    ST_RELEASE = 3'b100
  } bus_state_t;

  typedef struct packed {
    logic atomic;
    logic rd;
    logic [1:0] size;
    logic [1:0] offs;
    logic [SPACE_W-1:0] space;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } core_req_t;

endpackage : biu_pkg

/* bus_interface_unit.sv */
// bus interface unit: memory stage requests to external bus cycles
// assumes request and ready pins are asynchronous and pass two flip-flops first
// What this block does
// - one activity at a time: transfer, arbitration or idle
// - every read or write starts with address strobe low
// - read-not-write shows the transfer direction
// - four low-active lane selects show byte, halfword or word
// - address and space driven; data driven on stores, sampled on loads
// - transfer stays open until ready, external or wait-state generated
// - atomic load-store is a read then a write, nothing between
// - lock held low across both halves of an atomic pair
// - on request all drivers float and bus grant goes low
// - grant released the cycle after the synchronised request is released
// - only loads and stores in the memory stage ask for data
// - 26-bit word address on lines 27 to 2, 4-bit space id
// - big-endian lanes: offset zero is the most significant byte
// - wait-state generator gives ready the programmed count plus one cycle after address
`timescale 1ns/1ps
`default_nettype none
module bus_interface_unit
  import biu_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_B_I,
  // memory stage request
  input wire logic MEM_VALID_I,
  input wire logic MEM_IS_LDST_I,
  input wire logic MEM_ATOMIC_I,
  input wire logic MEM_READ_I,
  input wire logic [1:0] MEM_SIZE_I,
  input wire logic [1:0] MEM_OFFS_I,
  input wire logic [SPACE_W-1:0] MEM_SPACE_I,
  input wire logic [ADDR_W-1:0] MEM_ADDR_I,
  input wire logic [DATA_W-1:0] MEM_WDATA_I,
  output logic MEM_READY_O,
  // load result
  output logic MEM_RVALID_O,
  output logic [DATA_W-1:0] MEM_RDATA_O,
  // wait-state generator setting
  input wire logic WAIT_EN_I,
  input wire logic [WAIT_W-1:0] WAIT_COUNT_I,
  // external bus
  output logic ADDR_STROBE_N_O,
  output logic RD_WR_N_O,
  output logic [LANE_W-1:0] BYTE_LANE_SEL_N_O,
  output logic [ADDR_W-1:0] ADDR_O,
  output logic [SPACE_W-1:0] SPACE_IDENTIFIER_O,
  output logic [DATA_W-1:0] DATA_O,
  input wire logic [DATA_W-1:0] DATA_I,
  output logic DATA_OE_N_O,
  output logic CTRL_OE_N_O,
  output logic LOCK_N_O,
  input wire logic READY_N_I,
  output logic READY_N_O,
  output logic READY_OE_N_O,
  // arbitration
  input wire logic BUS_REQUEST_N_I,
  output logic BUS_GRANT_N_O
);

  // -------------------------------------------------------------
  // request path
  // -------------------------------------------------------------
  req_fifo_if #(.WIDTH(REQ_W)) rq ();
  logic in_valid;
  core_req_t in_req;

  assign in_valid = MEM_VALID_I && MEM_IS_LDST_I;
  assign in_req = '{atomic: MEM_ATOMIC_I, rd: MEM_READ_I,
                    size: MEM_SIZE_I, offs: MEM_OFFS_I,
                    space: MEM_SPACE_I, addr: MEM_ADDR_I,
                    wdata: MEM_WDATA_I};

  req_fifo #(.WIDTH(REQ_W), .DEPTH(DEPTH)) u_fifo (
    .clk_i(SYS_CLK_I),
    .rst_b_i(RST_B_I),
    .in_valid_i(in_valid),
    .in_ready_o(MEM_READY_O),
    .in_data_i(in_req),
    .out(rq)
  );

  // big-endian lanes; bit 3 is the most significant byte
  function automatic logic [3:0] lanes_n(input logic [1:0] size,
                                         input logic [1:0] offs);
    logic [3:0] on;
    on = 4'h0;
    case (size)
      SIZE_BYTE: on = 4'h8 >> offs;
      SIZE_HALF: on = offs[1] ? 4'h3 : 4'hc;
      default: on = 4'hf;
    endcase
    return ~on;
  endfunction : lanes_n

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    bus_state_t st;
    logic bus_request_n_m;
    logic bus_request_n_s;
    logic rdy_m;
    logic rdy_s;
    logic as_n;
    logic rd;
    logic [3:0] lanes_n;
    logic [ADDR_W-1:0] addr;
    logic [SPACE_W-1:0] space;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic lock_n;
    logic grant_n;
    logic float;
    logic [WAIT_W-1:0] wait_cnt;
    logic wait_rdy;
  } biu_state_t;

  biu_state_t s_r;
  biu_state_t s_nxt;
  logic bus_req;
  logic ready_hit;
  core_req_t head;

  assign head = core_req_t'(rq.data);
  assign bus_req = !s_r.bus_request_n_s;
  // ready from outside or from the generator; the pin is ignored while
  // the generator owns the range, else its own echo closes the next half
  assign ready_hit = WAIT_EN_I ? s_r.wait_rdy : !s_r.rdy_s;

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.bus_request_n_m = BUS_REQUEST_N_I;
    s_nxt.bus_request_n_s = s_r.bus_request_n_m;
    s_nxt.rdy_m = READY_N_I;
    s_nxt.rdy_s = s_r.rdy_m;
    s_nxt.rvalid = 1'b0;
    s_nxt.wait_rdy = 1'b0;
    rq.ready = 1'b0;
    // count from the cycle the address appears
    if (!s_r.as_n && WAIT_EN_I) begin
      if (s_r.wait_cnt == WAIT_COUNT_I) s_nxt.wait_rdy = !s_r.wait_rdy;
      else s_nxt.wait_cnt = s_r.wait_cnt + 1'b1;
    end
    case (s_r.st)
      ST_IDLE: begin
        if (bus_req) begin
          s_nxt.float = 1'b1;
          s_nxt.grant_n = 1'b0;
          s_nxt.st = ST_GRANT;
        // nothing starts under grant; request wins at idle
        end else if (rq.valid) begin
          rq.ready = 1'b1;
          s_nxt.as_n = 1'b0;
          s_nxt.rd = head.rd || head.atomic;
          s_nxt.lanes_n = lanes_n(head.size, head.offs);
          s_nxt.addr = head.addr;
          s_nxt.space = head.space;
          s_nxt.wdata = head.wdata;
          s_nxt.lock_n = !head.atomic;
          s_nxt.wait_cnt = WAIT_RST;
          s_nxt.st = ST_XFER;
        end
      end
      ST_XFER, ST_ATOM_WR: begin
        if (ready_hit) begin
          s_nxt.wait_cnt = WAIT_RST;
          s_nxt.wait_rdy = 1'b0;
          if (s_r.rd) begin
            s_nxt.rdata = DATA_I;
            s_nxt.rvalid = 1'b1;
          end
          // store follows the read at once
          if (!s_r.lock_n && s_r.st == ST_XFER) begin
            s_nxt.rd = 1'b0;
            s_nxt.st = ST_ATOM_WR;
          end else begin
            s_nxt.as_n = 1'b1;
            s_nxt.lock_n = 1'b1;
            s_nxt.lanes_n = LANES_NONE_N;
            s_nxt.st = ST_IDLE;
          end
        end
      end
      ST_GRANT: begin
        // grant drops in the cycle after request release
        if (!bus_req) begin
          s_nxt.grant_n = 1'b1;
          s_nxt.st = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        s_nxt.float = 1'b0;
        s_nxt.st = ST_IDLE;
      end
      default: s_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s_r <= '{st: ST_IDLE, bus_request_n_m: 1'b1, bus_request_n_s: 1'b1, rdy_m: 1'b1,
               rdy_s: 1'b1, as_n: 1'b1, rd: 1'b1,
               lanes_n: LANES_NONE_N, lock_n: 1'b1, grant_n: 1'b1,
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign ADDR_STROBE_N_O = s_r.as_n;
  assign RD_WR_N_O = s_r.rd;
  assign BYTE_LANE_SEL_N_O = s_r.lanes_n;
  assign ADDR_O = s_r.addr;
  assign SPACE_IDENTIFIER_O = s_r.space;
  assign DATA_O = s_r.wdata;
  // data bus driven only during a store we own
  assign DATA_OE_N_O = s_r.float || s_r.rd || s_r.as_n;
  assign CTRL_OE_N_O = s_r.float;
  assign LOCK_N_O = s_r.lock_n;
  assign BUS_GRANT_N_O = s_r.grant_n;
  assign READY_N_O = !s_r.wait_rdy;
  // shared ready line is driven only when the generator fires
  assign READY_OE_N_O = !s_r.wait_rdy;
  assign MEM_RVALID_O = s_r.rvalid;
  assign MEM_RDATA_O = s_r.rdata;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  sequence grant_seen;
    !BUS_GRANT_N_O;
  endsequence
  sequence req_gone;
    s_r.bus_request_n_s;
  endsequence

  a_grant_release: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_B_I) (grant_seen ##0 req_gone) |=> BUS_GRANT_N_O)
    else $error("grant not dropped after request release");
  a_float_on_grant: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_B_I) !BUS_GRANT_N_O |-> CTRL_OE_N_O)
    else $error("drivers active while granted");
  a_no_strobe_grant: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_B_I) !(!BUS_GRANT_N_O && !ADDR_STROBE_N_O))
    else $error("strobe under grant");
  a_hold_till_ready: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_B_I) (!ADDR_STROBE_N_O && !ready_hit)
      |=> !ADDR_STROBE_N_O && $stable(ADDR_O))
    else $error("transfer closed without ready");
  a_atomic_order: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_B_I) (s_r.st == ST_XFER && !LOCK_N_O && ready_hit)
      |=> !ADDR_STROBE_N_O && !RD_WR_N_O && !LOCK_N_O)
    else $error("atomic write did not follow read");
  a_lock_strobe: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_B_I) !LOCK_N_O |-> !ADDR_STROBE_N_O)
    else $error("lock outside a transfer");
  a_lane_width: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_B_I) !ADDR_STROBE_N_O |-> BYTE_LANE_SEL_N_O != 4'hf)
    else $error("no lane selected");
  a_store_drive: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_B_I) (!ADDR_STROBE_N_O && !RD_WR_N_O)
      |-> !DATA_OE_N_O)
    else $error("store data not driven");
  a_wait_count: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_B_I) $fell(ADDR_STROBE_N_O) && WAIT_EN_I
      && WAIT_COUNT_I == 4'h0 |=> !READY_N_O)
    else $error("wait-state ready late");
endmodule : bus_interface_unit
`default_nettype wire

/* ext_mem_model.sv */
// external memory model: answers strobed transfers after a set latency
// assumes the bench merges its ready with the generator ready on one wire
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // bus driven by the device
  input wire logic strobe_n_i,
  input wire logic rd_wr_n_i,
  input wire logic ctrl_oe_n_i,
  input wire logic data_oe_n_i,
  input wire logic [3:0] lanes_n_i,
  input wire logic [25:0] addr_i,
  input wire logic [31:0] data_i,
  input wire logic ready_wire_n_i,
  // bench controls
  input wire logic answer_en_i,
  input wire logic [3:0] lat_i,
  // answers
  output logic ready_n_o,
  output logic [31:0] data_o
);
  logic [31:0] mem [16];
  logic [31:0] junk_r;
  logic [3:0] cnt_r;
  logic done_r;
  logic rw_r;
  logic busy;

  // ---------------------------------------------------------------
  // read data and ready
  // ---------------------------------------------------------------
  // data only for an addressed read; a moving pattern otherwise
  assign busy = !strobe_n_i && !ctrl_oe_n_i;
  assign data_o = (busy && rd_wr_n_i) ? mem[addr_i[3:0]] : junk_r;

  // one ready per half; a direction flip opens a new half
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ready_n_o <= 1'b1;
      cnt_r <= 4'h0;
      done_r <= 1'b0;
      rw_r <= 1'b1;
      junk_r <= 32'h0f0f3c3c;
    end else begin
      junk_r <= {junk_r[30:0], ~junk_r[31]};
      rw_r <= rd_wr_n_i;
      ready_n_o <= 1'b1;
      if (!busy || rw_r != rd_wr_n_i) begin
        cnt_r <= 4'h0;
        done_r <= 1'b0;
      end else if (answer_en_i && !done_r) begin
        cnt_r <= cnt_r + 4'h1;
        // at least, not equal: latency may shrink mid-transfer
        if (cnt_r >= lat_i) begin
          ready_n_o <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  // store bytes land by lane, lane 3 the most significant
  always_ff @(posedge clk_i) begin
    if (busy && !ready_wire_n_i && !rd_wr_n_i && !data_oe_n_i) begin
      for (int b = 0; b < 4; b++) begin
        if (!lanes_n_i[b]) begin
          mem[addr_i[3:0]][8*b +: 8] <= data_i[8*b +: 8];
        end
      end
    end
  end
endmodule : ext_mem_model
`default_nettype wire

/* req_fifo.sv */
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an active low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module req_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  req_fifo_if.source out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] cnt_r;
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic push;
  logic pop;

  // honest flags straight from the count
  assign in_ready_o = (cnt_r != (PW+1)'(DEPTH));
  assign out.valid = (cnt_r != '0);
  assign out.data = mem[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out.valid && out.ready;

  // storage is not reset, only the pointers and the count are
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_r] <= in_data_i;
    end
  end

  // pointers wrap because depth is a power of two
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= '0;
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : req_fifo
`default_nettype wire

/* req_fifo_if.sv */
// carrier between the request fifo and the bus engine
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface req_fifo_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : req_fifo_if
`default_nettype wire

/* testbench.sv */
// bench for the bus interface unit with queued expectations
// assumes ext_mem_model answers on the external bus
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import biu_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, vld = 1'b0, ldst = 1'b0, at = 1'b0;
  logic rd = 1'b0, wen = 1'b0, ans = 1'b1, bus_request_n_n = 1'b1;
  logic [1:0] sz = 2'h0, of = 2'h0;
  logic [3:0] sp = 4'h0, wcnt = 4'h0, lat = 4'h0;
  logic [25:0] a = 26'h0;
  logic [31:0] wd = 32'h0;
  logic mrdy, rvalid, as_n, rw, doe_n, coe_n, lock_n, rdy_o, rdy_oe;
  logic gnt_n, ext_n, wire_n;
  logic [3:0] ln_n, sp_o;
  logic [25:0] adr;
  logic [31:0] rdata, dout, din, d;
  logic [31:0] shadow [16];
  logic [31:0] rd_q [$];
  logic [34:0] bus_q [$];
  logic as_q = 1'b1, refused = 1'b0, seen_wr;
  int fails = 0, n_tests = 0, seed = 23443, n;

  always #5 clk = ~clk;
  // ready wire: pulled up, low when either party pulls it
  assign wire_n = ext_n & (rdy_oe ? 1'b1 : rdy_o);

  bus_interface_unit i_dut (.SYS_CLK_I(clk), .RST_B_I(rst_b),
    .MEM_VALID_I(vld), .MEM_IS_LDST_I(ldst), .MEM_ATOMIC_I(at),
    .MEM_READ_I(rd), .MEM_SIZE_I(sz), .MEM_OFFS_I(of),
    .MEM_SPACE_I(sp), .MEM_ADDR_I(a), .MEM_WDATA_I(wd),
    .MEM_READY_O(mrdy), .MEM_RVALID_O(rvalid), .MEM_RDATA_O(rdata),
    .WAIT_EN_I(wen), .WAIT_COUNT_I(wcnt), .ADDR_STROBE_N_O(as_n),
    .RD_WR_N_O(rw), .BYTE_LANE_SEL_N_O(ln_n), .ADDR_O(adr),
    .SPACE_IDENTIFIER_O(sp_o), .DATA_O(dout), .DATA_I(din),
    .DATA_OE_N_O(doe_n), .CTRL_OE_N_O(coe_n), .LOCK_N_O(lock_n),
    .READY_N_I(wire_n), .READY_N_O(rdy_o), .READY_OE_N_O(rdy_oe),
    .BUS_REQUEST_N_I(bus_request_n_n), .BUS_GRANT_N_O(gnt_n));

  ext_mem_model i_mem (.clk_i(clk), .rst_b_i(rst_b), .strobe_n_i(as_n),
    .rd_wr_n_i(rw), .ctrl_oe_n_i(coe_n), .data_oe_n_i(doe_n),
    .lanes_n_i(ln_n), .addr_i(adr), .data_i(dout),
    .ready_wire_n_i(wire_n), .answer_en_i(ans), .lat_i(lat),
    .ready_n_o(ext_n), .data_o(din));

  // ---------------------------------------------------------------
  // checks and drivers
  // ---------------------------------------------------------------
  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask : chk

  task automatic close_out;
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task automatic tmo;
    if (n >= 300) begin
      fails++;
      close_out();
    end
  endtask : tmo

  function automatic logic [3:0] lanes(input logic [1:0] s, o);
    case (s)
      SIZE_BYTE: lanes = ~(4'h8 >> o);
      SIZE_HALF: lanes = o[1] ? 4'hc : 4'h3;
      default: lanes = 4'h0;
    endcase
  endfunction : lanes

  // hands one request over; valid stays up so calls may run back to back
  task automatic issue(input logic t, r, input logic [1:0] s, o,
                       input logic [3:0] ix, input logic [31:0] w);
    logic [3:0] l;
    l = lanes(s, o);
    {at, rd, sz, of, wd, vld, ldst} = {t, r, s, o, w, 2'h3};
    sp = 4'($random(seed));
    a = 26'($random(seed));
    a[3:0] = ix;
    if (r | t) rd_q.push_back(shadow[ix]);
    for (int b = 0; b < 4; b++) begin
      if (!(r & !t) && !l[b]) shadow[ix][8*b +: 8] = w[8*b +: 8];
    end
    bus_q.push_back({r | t, sp, a, l});
    for (n = 0; !mrdy && n < 300; n++) begin
      refused = 1'b1;
      @(negedge clk);
    end
    tmo();
    @(negedge clk);
  endtask : issue

  task automatic drain;
    vld = 1'b0;
    for (n = 0; (rd_q.size() || bus_q.size() || !as_n) && n < 300; n++) begin
      @(negedge clk);
    end
    tmo();
    repeat (2) @(negedge clk);
  endtask : drain

  task automatic wait_as;
    for (n = 0; as_n && n < 300; n++) @(negedge clk);
    tmo();
  endtask : wait_as

  // watcher: bus fields at each strobe fall, load data at each pulse
  always @(negedge clk) begin
    if (rst_b && as_q && !as_n) begin
      chk({rw, sp_o, adr, ln_n}, bus_q.size() > 0 ? bus_q.pop_front() :
          ~{rw, sp_o, adr, ln_n});
    end
    if (rvalid) chk(rdata, rd_q.size() > 0 ? rd_q.pop_front() : ~rdata);
    as_q = as_n;
  end

  initial begin
    for (int i = 0; i < 16; i++) shadow[i] = 32'h0;
    repeat (12) @(negedge clk);
    chk({as_n, lock_n, gnt_n}, 35'h7);
    rst_b = 1'b1;
    @(negedge clk);
    // byte, halfword and word stores at random latency, word read-back later
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      lat = d[3:0] & 4'h7;
      issue(1'b0, 1'b0, SIZE_BYTE, k[1:0], 4'h1, {4{d[7:0]}});
      issue(1'b0, 1'b0, SIZE_HALF, {k[0], 1'b0}, 4'h2, {2{d[15:0]}});
    end
    issue(1'b0, 1'b0, SIZE_WORD, 2'h0, 4'h3, d);
    // slow memory: the request fifo fills until it refuses
    lat = 4'hf;
    refused = 1'b0;
    for (int k = 0; k < 7; k++) begin
      issue(1'b0, 1'b1, SIZE_WORD, 2'h0, {3'h0, k[0]} + 4'h1, d);
    end
    chk(refused, 35'h1);
    drain();
    // an instruction that is no load or store asks for nothing
    ldst = 1'b0;
    vld = 1'b1;
    repeat (10) @(negedge clk);
    vld = 1'b0;
    // wait-state generator answers after the programmed count
    {ans, wen} = 2'h1;
    for (int k = 0; k < 3; k++) begin
      wcnt = 4'(k * 7);
      issue(1'b0, 1'b1, SIZE_WORD, 2'h0, 4'h2, d);
      vld = 1'b0;
      wait_as();
      for (n = 0; !(!rdy_oe && !rdy_o) && n < 300; n++) @(negedge clk);
      chk(n, wcnt + 35'h1);
      drain();
    end
    // atomic pair: read then write under one strobe, locked
    {ans, wen, lat, seen_wr} = {2'h2, 4'h2, 1'b0};
    issue(1'b1, 1'b1, SIZE_WORD, 2'h0, 4'h3, ~d);
    vld = 1'b0;
    wait_as();
    for (n = 0; !as_n && n < 300; n++) begin
      chk({lock_n, rw & seen_wr}, 35'h0);
      seen_wr = seen_wr | !rw;
      @(negedge clk);
    end
    chk(seen_wr, 35'h1);
    issue(1'b0, 1'b1, SIZE_WORD, 2'h0, 4'h3, d);
    drain();
    // outside master takes the bus while a read waits
    bus_request_n_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(gnt_n, 35'h1);
    @(negedge clk);
    chk({gnt_n, coe_n}, 35'h1);
    issue(1'b0, 1'b1, SIZE_WORD, 2'h0, 4'h1, d);
    vld = 1'b0;
    repeat (10) begin
      chk(as_n, 35'h1);
      @(negedge clk);
    end
    bus_request_n_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(gnt_n, 35'h0);
    @(negedge clk);
    chk(gnt_n, 35'h1);
    drain();
    close_out();
  end
endmodule : testbench
`default_nettype wire
